// [src/asfe_pkg.sv]
package asfe_pkg;
   // register addresses
   localparam logic [2:0] ASFE_A_TXC  = 3'h0;
   localparam logic [2:0] ASFE_A_RXC  = 3'h1;
   localparam logic [2:0] ASFE_A_BDC  = 3'h2;
   localparam logic [2:0] ASFE_A_DIVL = 3'h3;
   localparam logic [2:0] ASFE_A_DIVH = 3'h4;
   localparam logic [2:0] ASFE_A_RXD  = 3'h5;
   localparam logic [2:0] ASFE_A_TXD  = 3'h6;
   localparam logic [2:0] ASFE_A_STAT = 3'h7;
   // transmit_status_control fields
   localparam int ASFE_T_EN   = 0;
   localparam int ASFE_T_NINE = 1;
   localparam int ASFE_T_SYNC = 2;
   localparam int ASFE_T_MSTR = 3;
   localparam int ASFE_T_BRK  = 4;
   localparam int ASFE_T_INV  = 5;
   localparam int ASFE_T_D9   = 6;
   localparam logic [7:0] ASFE_T_WMASK = 8'h7F;
   // receive_status_control fields
   localparam int ASFE_R_ON    = 0;
   localparam int ASFE_R_CONT  = 1;
   localparam int ASFE_R_ADDR  = 2;
   localparam int ASFE_R_OERR  = 4;
   localparam int ASFE_R_FERR  = 5;
   localparam int ASFE_R_D9    = 6;
   localparam int ASFE_R_AVAIL = 7;
   localparam logic [7:0] ASFE_R_WMASK = 8'h07;
   // baud_control fields
   localparam int ASFE_B_W16    = 0;
   localparam int ASFE_B_WAKE   = 1;
   localparam int ASFE_B_ABD    = 2;
   localparam int ASFE_B_ABDOVF = 3;
   localparam int ASFE_B_WOKE   = 4;
   localparam logic [7:0] ASFE_B_WMASK = 8'h07;
   // line status fields
   localparam int ASFE_S_TRMT  = 0;
   localparam int ASFE_S_TBUFE = 1;
   localparam int ASFE_S_RIDLE = 2;
   localparam int ASFE_S_RFULL = 3;
   // reset values
   localparam logic [7:0]  ASFE_TXC_RST = 8'h00;
   localparam logic [7:0]  ASFE_RXC_RST = 8'h00;
   localparam logic [7:0]  ASFE_BDC_RST = 8'h00;
   localparam logic [15:0] ASFE_DIV_RST = 16'h0000;
   // bit timing, sixteen oversample ticks per bit
   localparam logic [3:0]  ASFE_TICK_LAST = 4'hF;
   localparam logic [3:0]  ASFE_TICK_MID  = 4'h7;
   localparam logic [3:0]  ASFE_BITS8     = 4'h8;
   localparam logic [3:0]  ASFE_BITS9     = 4'h9;
   localparam logic [3:0]  ASFE_FRAME8    = 4'hA;
   localparam logic [3:0]  ASFE_FRAME9    = 4'hB;
   localparam logic [3:0]  ASFE_FRAMEB    = 4'hE;
   localparam logic [13:0] ASFE_BRK_SH    = 14'h2000;
   localparam logic [13:0] ASFE_IDLE_SH   = 14'h3FFF;
   // auto-baud: five falling edges of the sync character span eight bits
   localparam logic [2:0]  ASFE_ABD_EDGES = 3'h4;
   localparam int          ASFE_ABD_SHIFT = 7;
   localparam logic [23:0] ASFE_ABD_MAX   = 24'hFF_FFFF;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } asfe_bus_t;

   typedef struct packed {
      logic ck_in;
      logic dt_in;
   } asfe_pin_in_t;

   typedef struct packed {
      logic ck_out;
      logic ck_oe;
      logic dt_out;
      logic dt_oe;
   } asfe_pin_out_t;

   typedef struct packed {
      logic       ferr;
      logic [8:0] d;
   } asfe_rxent_t;

   typedef enum logic [1:0] {
      ASFE_TX_IDLE  = 2'b00,
      ASFE_TX_ASYNC = 2'b01,
      ASFE_TX_SYNC  = 2'b10
   } asfe_txst_t;

   typedef enum logic [1:0] {
      ASFE_RX_IDLE  = 2'b00,
      ASFE_RX_START = 2'b01,
      ASFE_RX_DATA  = 2'b10,
      ASFE_RX_STOP  = 2'b11
   } asfe_rxst_t;

   typedef struct packed {
      logic [7:0]             txc;
      logic [7:0]             rxc;
      logic [7:0]             bdc;
      logic [15:0]            div;
      asfe_txst_t             tst;
      logic [13:0]            tsh;
      logic [3:0]             tlen;
      logic [3:0]             tbits;
      logic [3:0]             ttick;
      logic [8:0]             tbuf;
      logic                   tfull;
      logic                   ssrx;
      asfe_rxst_t             rst;
      logic [8:0]             rsh;
      logic [3:0]             rbits;
      logic [3:0]             rtick;
      asfe_rxent_t [1:0]      fifo;
      logic                   rhead;
      logic [1:0]             rcnt;
      logic                   oerr;
      logic                   woke;
      logic                   abdovf;
      logic [23:0]            acnt;
      logic [2:0]             aedg;
      logic [2:0]             dsy;
      logic [2:0]             csy;
      logic                   dflt;
      logic                   cflt;
      logic                   dprv;
      logic                   cprv;
      logic [7:0]             rdata;
      asfe_pin_out_t          po;
   } asfe_state_t;

   localparam asfe_state_t ASFE_ST_RST = '{
      txc: ASFE_TXC_RST, rxc: ASFE_RXC_RST, bdc: ASFE_BDC_RST, div: ASFE_DIV_RST,
      tst: ASFE_TX_IDLE, rst: ASFE_RX_IDLE, tsh: ASFE_IDLE_SH,
      dsy: 3'h7, dflt: 1'b1, dprv: 1'b1, default: '0};
endpackage

// [src/asfe_baud_gen.sv]
`timescale 1ns/1ns
module asfe_baud_gen (
   // clock, reset, enable
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        ce,
   // divider setting
   input  wire logic        wide,
   input  wire logic [15:0] divisor,
   // oversample tick
   output logic             tick
);
   typedef struct packed {
      logic [15:0] cnt;
      logic        tick;
   } asfe_bg_t;

   asfe_bg_t    s_q;
   asfe_bg_t    s_d;
   logic [15:0] lim;

   // 8-bit or 16-bit divider of the system clock
   always_comb begin
      lim    = wide ? divisor : {8'h00, divisor[7:0]};
      s_d    = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt >= lim) begin
         s_d.cnt  = 16'h0000;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;
endmodule

// [src/asfe_core.sv]
`timescale 1ns/1ns
// Behaviour
// R1: line rests at mark while no character is sent
// R2: mark is a one, space is a zero
// R3: equal successive bits hold the line with no return between bits
// R4: frame is one start bit, eight or nine data bits, one or more stops
// R5: start bit is space, stop bits are mark
// R6: every bit lasts one bit period of the configured baud rate
// R7: baud generator divides system clock, selectable 8-bit or 16-bit
// R8: data bits go least significant first
// R9: transmitter and receiver independent, sharing format and baud rate
// R10: no parity logic; ninth bit is plain data
// R11: asynchronous full duplex or synchronous half duplex master or slave
// R12: in synchronous mode software puts receive and data output on one pin
// R13: block itself drives the data pin output enable
// R14: synchronous slave takes bit timing from the master clock
// R15: transmitter can send a break of thirteen space bit periods
// R16: nine-bit address detection drops frames whose ninth bit is clear
// R17: overrun flagged when a character completes with the buffer full
// R18: framing error flagged when the stop bit is not mark
// R19: auto-baud detection and calibration, and wake on break
// R20: receiver oversamples at sixteen times the baud rate
// R21: received characters enter a two character FIFO
// R22: queued character enters the shifter one cycle after the stop bit
// R23: ninth data bit goes last before the stop bit
// R24: start found on first falling edge; bits sampled mid period
module asfe_core (
   // clock, reset, enable
   input  wire logic                    clk,
   input  wire logic                    reset,
   input  wire logic                    ce,
   // register port
   input  wire asfe_pkg::asfe_bus_t     bus,
   output logic [7:0]                   rdata,
   // serial pins
   input  wire asfe_pkg::asfe_pin_in_t  pins_in,
   output asfe_pkg::asfe_pin_out_t      pins_out
);
   asfe_pkg::asfe_state_t s_q;
   asfe_pkg::asfe_state_t s_d;
   asfe_pkg::asfe_rxent_t head;
   asfe_pkg::asfe_rxent_t pw;
   logic                  tick;
   logic                  spen;
   logic                  txen;
   logic                  nine;
   logic                  sync;
   logic                  mstr;
   logic                  cren;
   logic                  rx_en;
   logic                  dfall;
   logic                  srise;
   logic                  sfall;
   logic                  push_v;
   logic                  drop;
   logic                  pop;
   logic                  acc;
   logic [3:0]            dbits;
   logic [15:0]           abd_div;

   // data bits per character, or bit periods per asynchronous frame
   function automatic logic [3:0] asfe_len(input logic nine9, input logic frame);
      logic [3:0] n;
      if (frame) begin
         n = nine9 ? asfe_pkg::ASFE_FRAME9 : asfe_pkg::ASFE_FRAME8;
      end else begin
         n = nine9 ? asfe_pkg::ASFE_BITS9 : asfe_pkg::ASFE_BITS8;
      end
      return n;
   endfunction

   // one divider serves both directions
   asfe_baud_gen u_baud (
      .clk     (clk),
      .reset   (reset),
      .ce      (ce),
      .wide    (s_q.bdc[asfe_pkg::ASFE_B_W16]),
      .divisor (s_q.div),
      .tick    (tick)
   ); // R7 R9

   always_comb begin
      s_d     = s_q;
      spen    = s_q.rxc[asfe_pkg::ASFE_R_ON];
      cren    = s_q.rxc[asfe_pkg::ASFE_R_CONT];
      txen    = s_q.txc[asfe_pkg::ASFE_T_EN];
      nine    = s_q.txc[asfe_pkg::ASFE_T_NINE];
      sync    = s_q.txc[asfe_pkg::ASFE_T_SYNC];
      mstr    = s_q.txc[asfe_pkg::ASFE_T_MSTR];
      rx_en   = spen & ~sync & cren;
      dbits   = asfe_len(nine, 1'b0); // R9
      dfall   = s_q.dprv & ~s_q.dflt;
      // master times the clock from ticks, slave from the clock pin
      srise   = mstr ? (tick && s_q.ttick == asfe_pkg::ASFE_TICK_MID)
                     : (~s_q.cprv & s_q.cflt); // R14
      sfall   = mstr ? (tick && s_q.ttick == asfe_pkg::ASFE_TICK_LAST)
                     : (s_q.cprv & ~s_q.cflt);
      head    = s_q.fifo[s_q.rhead];
      pop     = bus.rd && bus.addr == asfe_pkg::ASFE_A_RXD && s_q.rcnt != 2'h0;
      push_v  = 1'b0;
      pw      = '0;
      drop    = 1'b0;
      acc     = 1'b0;
      abd_div = 16'(s_q.acnt >> asfe_pkg::ASFE_ABD_SHIFT) - 16'h0001;
      s_d.rdata = 8'h00;

      // pin synchronisers; a change counts once stages two and three agree
      s_d.dsy  = {s_q.dsy[1:0], pins_in.dt_in};
      s_d.csy  = {s_q.csy[1:0], pins_in.ck_in};
      if (s_q.dsy[1] == s_q.dsy[2]) begin
         s_d.dflt = s_q.dsy[2];
      end
      if (s_q.csy[1] == s_q.csy[2]) begin
         s_d.cflt = s_q.csy[2];
      end
      s_d.dprv = s_q.dflt;
      s_d.cprv = s_q.cflt;

      // register writes
      if (bus.wr) begin
         case (bus.addr)
            asfe_pkg::ASFE_A_TXC: begin
               s_d.txc = bus.wdata & asfe_pkg::ASFE_T_WMASK;
            end
            asfe_pkg::ASFE_A_RXC: begin
               s_d.rxc = bus.wdata & asfe_pkg::ASFE_R_WMASK;
            end
            asfe_pkg::ASFE_A_BDC: begin
               s_d.bdc = bus.wdata & asfe_pkg::ASFE_B_WMASK;
               if (bus.wdata[asfe_pkg::ASFE_B_ABDOVF]) begin
                  s_d.abdovf = 1'b0;
               end
               if (bus.wdata[asfe_pkg::ASFE_B_WOKE]) begin
                  s_d.woke = 1'b0;
               end
               s_d.aedg = 3'h0;
            end
            asfe_pkg::ASFE_A_DIVL: begin
               s_d.div[7:0] = bus.wdata;
            end
            asfe_pkg::ASFE_A_DIVH: begin
               s_d.div[15:8] = bus.wdata;
            end
            asfe_pkg::ASFE_A_TXD: begin
               if (!s_q.tfull) begin
                  s_d.tfull = 1'b1;
                  s_d.tbuf  = {s_q.txc[asfe_pkg::ASFE_T_D9], bus.wdata}; // R10
               end
            end
            default: begin
            end
         endcase
      end

      // register reads, data in the next cycle only
      if (bus.rd) begin
         case (bus.addr)
            asfe_pkg::ASFE_A_TXC: begin
               s_d.rdata = s_q.txc;
            end
            asfe_pkg::ASFE_A_RXC: begin
               s_d.rdata = s_q.rxc;
               s_d.rdata[asfe_pkg::ASFE_R_OERR]  = s_q.oerr;
               s_d.rdata[asfe_pkg::ASFE_R_FERR]  = head.ferr;
               s_d.rdata[asfe_pkg::ASFE_R_D9]    = head.d[8];
               s_d.rdata[asfe_pkg::ASFE_R_AVAIL] = s_q.rcnt != 2'h0;
            end
            asfe_pkg::ASFE_A_BDC: begin
               s_d.rdata = s_q.bdc;
               s_d.rdata[asfe_pkg::ASFE_B_ABDOVF] = s_q.abdovf;
               s_d.rdata[asfe_pkg::ASFE_B_WOKE]   = s_q.woke;
            end
            asfe_pkg::ASFE_A_DIVL: begin
               s_d.rdata = s_q.div[7:0];
            end
            asfe_pkg::ASFE_A_DIVH: begin
               s_d.rdata = s_q.div[15:8];
            end
            asfe_pkg::ASFE_A_RXD: begin
               s_d.rdata = head.d[7:0];
            end
            asfe_pkg::ASFE_A_STAT: begin
               s_d.rdata[asfe_pkg::ASFE_S_TRMT]  = s_q.tst == asfe_pkg::ASFE_TX_IDLE;
               s_d.rdata[asfe_pkg::ASFE_S_TBUFE] = ~s_q.tfull;
               s_d.rdata[asfe_pkg::ASFE_S_RIDLE] = s_q.rst == asfe_pkg::ASFE_RX_IDLE;
               s_d.rdata[asfe_pkg::ASFE_S_RFULL] = s_q.rcnt == 2'h2;
            end
            default: begin
            end
         endcase
      end

      // transmitter and synchronous transfer engine
      case (s_q.tst)
         asfe_pkg::ASFE_TX_IDLE: begin
            s_d.tsh   = asfe_pkg::ASFE_IDLE_SH; // R1
            s_d.ttick = 4'h0;
            s_d.tbits = 4'h0;
            if (spen && txen && s_q.tfull) begin
               s_d.tfull = 1'b0; // R22
               if (sync) begin
                  s_d.tst  = asfe_pkg::ASFE_TX_SYNC; // R11
                  s_d.ssrx = 1'b0;
                  s_d.tsh  = {5'h1F, s_q.tbuf};
               end else if (s_q.txc[asfe_pkg::ASFE_T_BRK]) begin
                  s_d.tst  = asfe_pkg::ASFE_TX_ASYNC;
                  s_d.tsh  = asfe_pkg::ASFE_BRK_SH; // R15
                  s_d.tlen = asfe_pkg::ASFE_FRAMEB;
                  s_d.txc[asfe_pkg::ASFE_T_BRK] = 1'b0;
               end else begin
                  s_d.tst  = asfe_pkg::ASFE_TX_ASYNC;
                  // start zero, data lsb first, ninth bit, then stop ones
                  s_d.tsh  = {4'hF, nine ? s_q.tbuf[8] : 1'b1, s_q.tbuf[7:0], 1'b0}; // R4 R5 R8 R23
                  s_d.tlen = asfe_len(nine, 1'b1);
               end
            end else if (spen && sync && cren) begin
               s_d.tst  = asfe_pkg::ASFE_TX_SYNC;
               s_d.ssrx = 1'b1;
            end
         end
         asfe_pkg::ASFE_TX_ASYNC: begin
            if (tick) begin
               if (s_q.ttick == asfe_pkg::ASFE_TICK_LAST) begin
                  s_d.ttick = 4'h0;
                  s_d.tsh   = {1'b1, s_q.tsh[13:1]}; // R2 R3 R6
                  s_d.tbits = s_q.tbits + 4'h1;
                  if (s_d.tbits == s_q.tlen) begin
                     s_d.tst = asfe_pkg::ASFE_TX_IDLE;
                  end
               end else begin
                  s_d.ttick = s_q.ttick + 4'h1;
               end
            end
         end
         asfe_pkg::ASFE_TX_SYNC: begin
            if (mstr && tick) begin
               s_d.ttick = s_q.ttick + 4'h1;
            end
            if (srise) begin
               s_d.tbits = s_q.tbits + 4'h1;
               if (s_q.ssrx) begin
                  s_d.rsh = {s_q.dflt, s_q.rsh[8:1]}; // R8
                  push_v  = s_d.tbits == dbits;
               end
            end
            if (sfall) begin
               s_d.tsh = {1'b1, s_q.tsh[13:1]};
            end
            if (s_d.tbits == dbits && (!mstr || sfall)) begin
               s_d.tst = asfe_pkg::ASFE_TX_IDLE;
            end
         end
         default: begin
            s_d.tst = asfe_pkg::ASFE_TX_IDLE;
         end
      endcase

      // asynchronous receiver, sixteen ticks per bit
      case (s_q.rst)
         asfe_pkg::ASFE_RX_IDLE: begin
            s_d.rtick = 4'h0;
            s_d.rbits = 4'h0;
            if (rx_en && dfall && !s_q.bdc[asfe_pkg::ASFE_B_WAKE]
                && !s_q.bdc[asfe_pkg::ASFE_B_ABD]) begin
               s_d.rst = asfe_pkg::ASFE_RX_START; // R24
            end
         end
         asfe_pkg::ASFE_RX_START: begin
            if (tick) begin
               s_d.rtick = s_q.rtick + 4'h1;
               if (s_q.rtick == asfe_pkg::ASFE_TICK_MID) begin
                  s_d.rtick = 4'h0;
                  s_d.rst   = s_q.dflt ? asfe_pkg::ASFE_RX_IDLE : asfe_pkg::ASFE_RX_DATA; // R24
               end
            end
         end
         asfe_pkg::ASFE_RX_DATA: begin
            if (tick) begin
               s_d.rtick = s_q.rtick + 4'h1; // R20
               if (s_q.rtick == asfe_pkg::ASFE_TICK_LAST) begin
                  s_d.rsh   = {s_q.dflt, s_q.rsh[8:1]}; // R8 R20
                  s_d.rbits = s_q.rbits + 4'h1;
                  if (s_d.rbits == dbits) begin
                     s_d.rst = asfe_pkg::ASFE_RX_STOP;
                  end
               end
            end
         end
         asfe_pkg::ASFE_RX_STOP: begin
            if (tick) begin
               s_d.rtick = s_q.rtick + 4'h1;
               if (s_q.rtick == asfe_pkg::ASFE_TICK_LAST) begin
                  push_v  = 1'b1;
                  pw.ferr = ~s_q.dflt; // R18
                  s_d.rst = asfe_pkg::ASFE_RX_IDLE;
               end
            end
         end
         default: begin
            s_d.rst = asfe_pkg::ASFE_RX_IDLE;
         end
      endcase
      if (!rx_en) begin
         s_d.rst = asfe_pkg::ASFE_RX_IDLE;
      end
      if (!spen) begin
         s_d.tst = asfe_pkg::ASFE_TX_IDLE;
      end

      // wake on the falling edge that opens a break
      if (spen && s_q.bdc[asfe_pkg::ASFE_B_WAKE] && dfall) begin
         s_d.woke = 1'b1; // R19
         s_d.bdc[asfe_pkg::ASFE_B_WAKE] = 1'b0;
      end

      // auto-baud: time eight bits of the sync character
      if (rx_en && s_q.bdc[asfe_pkg::ASFE_B_ABD]) begin
         if (s_q.aedg != 3'h0) begin
            s_d.acnt = s_q.acnt + 24'h00_0001;
         end
         if (s_q.aedg != 3'h0 && s_q.acnt == asfe_pkg::ASFE_ABD_MAX) begin
            s_d.abdovf = 1'b1;
            s_d.aedg   = 3'h0;
            s_d.bdc[asfe_pkg::ASFE_B_ABD] = 1'b0;
         end else if (dfall) begin
            if (s_q.aedg == asfe_pkg::ASFE_ABD_EDGES) begin
               s_d.div  = abd_div; // R19
               s_d.aedg = 3'h0;
               s_d.bdc[asfe_pkg::ASFE_B_W16] = 1'b1;
               s_d.bdc[asfe_pkg::ASFE_B_ABD] = 1'b0;
            end else begin
               s_d.aedg = s_q.aedg + 3'h1;
               if (s_q.aedg == 3'h0) begin
                  s_d.acnt = 24'h00_0000;
               end
            end
         end
      end

      // two entry receive FIFO with overrun and address filtering
      pw.d = nine ? s_d.rsh : {1'b0, s_d.rsh[8:1]};
      drop = push_v & s_q.rxc[asfe_pkg::ASFE_R_ADDR] & nine & ~pw.d[8]; // R16
      if (!cren) begin
         s_d.oerr = 1'b0;
      end
      if (pop) begin
         s_d.rhead = ~s_q.rhead;
      end
      if (push_v && !drop) begin
         if (s_q.rcnt == 2'h2 && !pop) begin
            s_d.oerr = 1'b1; // R17
         end else begin
            acc = 1'b1;
            s_d.fifo[s_q.rhead ^ s_q.rcnt[0]] = pw; // R21
         end
      end
      s_d.rcnt = s_q.rcnt + {1'b0, acc} - {1'b0, pop};

      // pin drivers follow the mode without software help
      s_d.po.ck_oe  = spen & (sync ? mstr : txen); // R11 R13
      s_d.po.ck_out = sync ? (s_d.tst == asfe_pkg::ASFE_TX_SYNC && s_d.ttick[3])
                           : (s_d.tsh[0] ^ s_q.txc[asfe_pkg::ASFE_T_INV]); // R1
      s_d.po.dt_oe  = spen & sync & (s_d.tst == asfe_pkg::ASFE_TX_SYNC) & ~s_d.ssrx; // R13
      s_d.po.dt_out = s_d.tsh[0];
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_q <= asfe_pkg::ASFE_ST_RST;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign rdata    = s_q.rdata;
   assign pins_out = s_q.po;
endmodule

// [tb/asfe_checker.sv]
`timescale 1ns/1ns
module asfe_checker (
   // clock and reset
   input wire logic                    clk,
   input wire logic                    reset,
   // register port
   input wire asfe_pkg::asfe_bus_t     bus,
   input wire logic [7:0]              rdata,
   // pins
   input wire asfe_pkg::asfe_pin_out_t pins_out
);
   logic [8:0] run_q;
   logic [8:0] idle_q;
   logic       sync_q;
   wire        tx    = pins_out.ck_out;
   wire        oe    = pins_out.ck_oe;
   wire        txd_w = bus.wr && bus.addr == asfe_pkg::ASFE_A_TXD;
   wire        txd_r = bus.rd && bus.addr == asfe_pkg::ASFE_A_TXD;
   wire        txc_w = bus.wr && bus.addr == asfe_pkg::ASFE_A_TXC;
   wire        off_w = txc_w && bus.wdata[1:0] == 2'b00 && !bus.wdata[3:2];
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // run length of the line level, time since last transmit write
   always_ff @(posedge clk) begin
      if (reset) begin
         run_q  <= 9'h000;
         idle_q <= 9'h000;
         sync_q <= 1'b0;
      end else begin
         run_q  <= $changed(tx) ? 9'h000 : run_q + 9'h001;
         idle_q <= txd_w ? 9'h000 : idle_q + {8'h00, idle_q != 9'h1FF};
         sync_q <= txc_w ? bus.wdata[asfe_pkg::ASFE_T_SYNC] : sync_q;
      end
   end
   a_rdata_zero: assert property (!bus.rd |=> rdata == 8'h00)
      else $error("rdata not zero after idle cycle");
   a_txd_read: assert property (txd_r |=> rdata == 8'h00)
      else $error("transmit buffer read not zero");
   a_start_len: assert property (!sync_q && $fell(tx) && oe |-> (!tx)[*8] ##1 (!tx)[*8])
      else $error("start bit shorter than one bit");
   a_low_run: assert property (!sync_q && $rose(tx) && $past(oe) |-> run_q[3:0] == 4'hF)
      else $error("space run not whole bits");
   a_break_bound: assert property (!sync_q && !tx && $stable(tx) && oe |-> run_q < 9'h0CF)
      else $error("space run longer than a break");
   a_idle_mark: assert property (!sync_q && idle_q == 9'h1F4 && oe |-> tx)
      else $error("line not at mark when idle");
   a_oe_follow: assert property (off_w |-> ##[1:3] !oe)
      else $error("line driver still on after disable");
   a_dt_idle: assert property ((!sync_q)[*4] |-> !pins_out.dt_oe)
      else $error("data pin driven in async mode");
endmodule

// [tb/asfe_peer.sv]
`timescale 1ns/1ns
module asfe_peer #(
   parameter int BIT = 16
) (
   // clock
   input wire logic clk,
   // serial lines
   input wire logic line_in,
   output logic     line_out
);
   logic [9:0] got_q[$];
   int         nbits = 8;
   int         run = 0;
   int         low_len = 0;
   initial line_out = 1'b1;
   // one frame, stop level chosen by caller
   task automatic send(input logic [8:0] d, input logic stop);
      @(posedge clk) line_out <= 1'b0;
      repeat (BIT - 1) @(posedge clk);
      for (int i = 0; i < nbits; i++) begin
         @(posedge clk) line_out <= d[i];
         repeat (BIT - 1) @(posedge clk);
      end
      @(posedge clk) line_out <= stop;
      repeat (BIT - 1) @(posedge clk);
      @(posedge clk) line_out <= 1'b1;
      repeat (BIT) @(posedge clk);
   endtask
   // receiver, bit 9 of an entry flags a missing stop
   initial begin
      logic [9:0] v;
      forever begin
         @(negedge clk iff line_in);
         @(negedge clk iff !line_in);
         repeat (BIT / 2 - 1) @(negedge clk);
         for (int i = 0; i <= nbits; i++) begin
            repeat (BIT) @(negedge clk);
            v[i] = line_in;
         end
         got_q.push_back({~v[nbits], nbits == 9 && v[8], v[7:0]});
      end
   end
   // length of the last space run
   always @(negedge clk) begin
      if (!line_in) run = run + 1;
      else begin
         if (run != 0) low_len = run;
         run = 0;
      end
   end
endmodule

// [tb/tb_async_serial_frame_engine.sv]
`timescale 1ns/1ns
module tb_async_serial_frame_engine;
   logic                    clk, reset, ce;
   asfe_pkg::asfe_bus_t     bus;
   logic [7:0]              rdata;
   asfe_pkg::asfe_pin_in_t  pin_i;
   asfe_pkg::asfe_pin_out_t pin_o;
   wire                     tx_line = pin_o.ck_oe ? pin_o.ck_out : 1'b1;
   wire                     rx_line;
   int                      fails = 0;
   int                      checks_done = 0;
   logic [7:0]              sdat;
   // transmit byte, receive byte
   logic [15:0]             rows [4] = '{16'h003C, 16'hFF80, 16'hA5FF, 16'h0100};
   assign pin_i = '{ck_in: pin_o.ck_out, dt_in: pin_o.dt_oe ? pin_o.dt_out : rx_line};
   asfe_core DUT (.clk(clk), .reset(reset), .ce(ce), .bus(bus), .rdata(rdata),
                  .pins_in(pin_i), .pins_out(pin_o));
   asfe_peer peer (.clk(clk), .line_in(tx_line), .line_out(rx_line));
   // synchronous slave: data pin shifted in on each master clock rise
   always @(posedge pin_o.ck_out)
      if (pin_o.dt_oe) sdat <= {pin_o.dt_out, sdat[7:1]};
   task automatic stop_test;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [9:0] s, input logic [9:0] e);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk) bus <= '0;
   endtask
   task automatic rc(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk) bus <= '0;
      #1 chk("rdata", {2'b00, rdata}, {2'b00, e});
   endtask
   task automatic pk(input logic [9:0] e);
      for (int i = 0; i < 3000 && peer.got_q.size() == 0; i++) @(posedge clk);
      if (peer.got_q.size() == 0) begin
         fails++;
         stop_test();
      end else begin
         chk("line", peer.got_q.pop_front(), e);
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      reset = 1'b1;
      ce = 1'b1;
      bus = '0;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      for (int a = 0; a < 5; a++) rc(a[2:0], 8'h00);
      rc(3'h6, 8'h00);
      wr(3'h4, 8'h01);
      wr(3'h1, 8'h03);
      wr(3'h0, 8'h01);
      foreach (rows[i]) begin
         fork
            wr(3'h6, rows[i][15:8]);
            peer.send({1'b0, rows[i][7:0]}, 1'b1);
         join
         pk({2'b00, rows[i][15:8]});
         rc(3'h5, rows[i][7:0]);
      end
      // back to back, second waits in the buffer
      wr(3'h6, 8'h81);
      @(posedge clk);
      wr(3'h6, 8'h7E);
      pk(10'h081);
      pk(10'h07E);
      // nine bits and address detection
      wr(3'h0, 8'h43);
      peer.nbits = 9;
      wr(3'h6, 8'h12);
      pk(10'h112);
      wr(3'h1, 8'h07);
      peer.send(9'h0AB, 1'b1);
      peer.send(9'h1CD, 1'b1);
      rc(3'h1, 8'hC7);
      rc(3'h5, 8'hCD);
      wr(3'h0, 8'h01);
      wr(3'h1, 8'h03);
      peer.nbits = 8;
      // stop bit missing
      peer.send(9'h05A, 1'b0);
      rc(3'h1, 8'hA3);
      rc(3'h5, 8'h5A);
      // third character overruns the full fifo
      for (int k = 1; k < 4; k++) peer.send({5'h03, k[3:0]}, 1'b1);
      rc(3'h1, 8'h93);
      rc(3'h5, 8'h31);
      rc(3'h5, 8'h32);
      wr(3'h1, 8'h01);
      wr(3'h1, 8'h03);
      rc(3'h1, 8'h03);
      // wake arm: the opening fall sets woke and disarms, no character taken
      wr(3'h2, 8'h02);
      peer.send(9'h000, 1'b1);
      rc(3'h2, 8'h10);
      // break of thirteen space bits
      wr(3'h0, 8'h11);
      wr(3'h6, 8'h00);
      pk(10'h200);
      for (int i = 0; i < 300 && !tx_line; i++) @(posedge clk);
      repeat (2) @(negedge clk);
      chk("space_run", peer.low_len[9:0], 10'h0D0);
      wr(3'h0, 8'h00);
      repeat (4) @(posedge clk);
      chk("line_oe", {9'h000, pin_o.ck_oe}, 10'h000);
      // synchronous master sends one byte, then releases the data pin
      wr(3'h1, 8'h01);
      wr(3'h0, 8'h0D);
      wr(3'h6, 8'hC3);
      repeat (150) @(posedge clk);
      chk("sync_data", {2'b00, sdat}, 10'h0C3);
      chk("data_oe", {9'h000, pin_o.dt_oe}, 10'h000);
      // mid-run reset, then a write frozen by the clock enable
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      ce    <= 1'b0;
      wr(3'h4, 8'h5A);
      ce    <= 1'b1;
      rc(3'h0, 8'h00);
      rc(3'h4, 8'h00);
      chk("line_oe_rst", {9'h000, pin_o.ck_oe}, 10'h000);
      stop_test();
   end
endmodule
bind asfe_core asfe_checker chk_i (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
                                   .pins_out(pins_out));
